/* File: include/servo_ref_pkg.sv */
package servo_ref_pkg;

  // ---------------------------------------------------------------
  // parameter addresses, reset values and ranges
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_ACCEL_PERIOD  = 12'h0244;  // acceleration period, ms
  localparam logic [11:0] ADDR_DECEL_PERIOD  = 12'h0246;  // deceleration period, ms
  localparam logic [11:0] ADDR_TORQUE_FS     = 12'h0252;  // torque at 10 V, percent
  localparam logic [15:0] RST_ACCEL_PERIOD   = 16'h001e;  // 30 ms
  localparam logic [15:0] RST_DECEL_PERIOD   = 16'h001e;  // 30 ms
  localparam logic [15:0] RST_TORQUE_FS      = 16'h0064;  // 100 percent
  localparam logic [15:0] PERIOD_MIN         = 16'h0006;  // 6 ms
  localparam logic [15:0] PERIOD_MAX         = 16'hffdc;  // 65500 ms
  localparam logic [15:0] TORQUE_FS_MAX      = 16'h03e8;  // 1000 percent
  localparam logic [15:0] PRESET_LIMIT       = 16'h012c;  // 300 percent
  localparam logic [31:0] RAMP_FULL_RPM      = 32'h0000_1770; // 6000 rpm per period

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLOCK_MHZ       = 50;    // clock rate
  localparam int RAMP_TICK_US    = 1000;  // ramp time base, one millisecond
  localparam int RAMP_TICK_CYCLES = RAMP_TICK_US * CLOCK_MHZ;

  // analog input: signed sample, full positive code equals 10 V
  localparam int ANALOG_FS_SHIFT = 15;

  // ---------------------------------------------------------------
  // operating modes and torque select codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    pulse_train_mode,
    internal_position_mode,
    velocity_mode,
    torque_mode,
    torque_zero_mode
  } opMode_e;

  localparam logic [1:0] SEL_ANALOG = 2'h0;  // analog or zero
  localparam logic [1:0] SEL_ONE    = 2'h1;  // preset one
  localparam logic [1:0] SEL_TWO    = 2'h2;  // preset two

  // parameter access carrier
  typedef struct packed {
    logic        write;   // one-cycle write strobe
    logic        read;    // one-cycle read strobe
    logic [11:0] addr;    // parameter address
    logic [15:0] wdata;   // write value
  } parReq_s;

  // torque preset set
  typedef struct packed {
    logic signed [15:0] presetOne;
    logic signed [15:0] presetTwo;
    logic signed [15:0] presetThree;
  } torquePreset_s;

endpackage

/* File: hdl/servo_ramp_torque_reference.sv */
`timescale 1ns/1ps
module servo_ramp_torque_reference
  import servo_ref_pkg::*;
#(
  parameter int TICK_CYCLES = RAMP_TICK_CYCLES  // clocks per millisecond
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // parameter access
  input  wire parReq_s              parReq,
  output logic               [15:0] parRdData,
  // mode and digital inputs
  input  wire opMode_e              opMode,
  input  wire logic                 servo_on_input,
  input  wire logic                 torque_select_bit0,
  input  wire logic                 torque_select_bit1,
  // references
  input  wire logic signed   [15:0] velocityTarget,
  input  wire logic signed   [15:0] pulse_train_input,
  input  wire logic signed   [15:0] analogTorque,
  input  wire torquePreset_s        torquePresets,
  // outputs
  output logic signed        [15:0] velocityRef,
  output logic signed        [15:0] torqueRef,
  output logic               [15:0] torqueLimit,
  output logic                      powerStageEnable
);

  // ---------------------------------------------------------------
  // parameter registers
  // ---------------------------------------------------------------
  logic [15:0] accel_period_ff, nxt_accel_period;     // accel ramp period
  logic [15:0] decel_period_ff, nxt_decel_period;     // decel ramp period
  logic [15:0] torque_full_scale_ff, nxt_torque_full_scale; // percent at 10 V
  logic [15:0] rdData_ff, nxt_rdData;                 // read answer

  wire periodOk = (parReq.wdata >= PERIOD_MIN) && (parReq.wdata <= PERIOD_MAX);

  // write decode and read mux
  always_comb begin
    nxt_accel_period      = accel_period_ff;
    nxt_decel_period      = decel_period_ff;
    nxt_torque_full_scale = torque_full_scale_ff;
    nxt_rdData            = rdData_ff;
    if (parReq.write) begin
      unique case (parReq.addr)
        ADDR_ACCEL_PERIOD: if (periodOk) nxt_accel_period = parReq.wdata;
        ADDR_DECEL_PERIOD: if (periodOk) nxt_decel_period = parReq.wdata;
        ADDR_TORQUE_FS: begin
          if (!servo_on_input && parReq.wdata <= TORQUE_FS_MAX)
            nxt_torque_full_scale = parReq.wdata;
        end
        default: ;  // unmapped write ignored
      endcase
    end
    if (parReq.read) begin
      unique case (parReq.addr)
        ADDR_ACCEL_PERIOD: nxt_rdData = accel_period_ff;
        ADDR_DECEL_PERIOD: nxt_rdData = decel_period_ff;
        ADDR_TORQUE_FS:    nxt_rdData = torque_full_scale_ff;
        default:           nxt_rdData = 16'h0000;  // unmapped reads zero
      endcase
    end
  end

  // register the parameters
  always_ff @(posedge clock) begin
    if (reset) begin
      accel_period_ff      <= RST_ACCEL_PERIOD;
      decel_period_ff      <= RST_DECEL_PERIOD;
      torque_full_scale_ff <= RST_TORQUE_FS;
      rdData_ff            <= 16'h0000;
    end else begin
      accel_period_ff      <= nxt_accel_period;
      decel_period_ff      <= nxt_decel_period;
      torque_full_scale_ff <= nxt_torque_full_scale;
      rdData_ff            <= nxt_rdData;
    end
  end

  assign parRdData = rdData_ff;

  // ---------------------------------------------------------------
  // millisecond tick divider
  // ---------------------------------------------------------------
  logic [31:0] tickCnt_ff, nxt_tickCnt;  // cycle counter
  logic        msTick;                   // one-cycle enable

  always_comb begin
    msTick      = (tickCnt_ff == 32'(TICK_CYCLES - 1));
    nxt_tickCnt = msTick ? 32'h0000_0000 : tickCnt_ff + 32'h0000_0001;
  end

  always_ff @(posedge clock) begin
    if (reset) tickCnt_ff <= 32'h0000_0000;
    else       tickCnt_ff <= nxt_tickCnt;
  end

  // ---------------------------------------------------------------
  // velocity ramp
  // ---------------------------------------------------------------
  logic signed [15:0] velRef_ff, nxt_velRef;  // ramped reference, rpm
  logic        [31:0] rateAcc_ff, nxt_rateAcc; // rpm credit times period
  logic signed [15:0] rampTarget;             // what the ramp chases
  logic        [15:0] activePeriod;           // accel or decel period
  logic               rampActive;             // mode uses the ramp
  logic               slowing;                // magnitude is falling
  logic        [31:0] accSum;                 // credit after this tick

  always_comb begin
    rampActive = (opMode == velocity_mode) || (opMode == pulse_train_mode);
    rampTarget = (opMode == velocity_mode) ? velocityTarget : pulse_train_input;
    slowing    = (velRef_ff > 16'sh0000 && rampTarget < velRef_ff) ||
                 (velRef_ff < 16'sh0000 && rampTarget > velRef_ff);
    activePeriod = slowing ? decel_period_ff : accel_period_ff;
    accSum     = msTick ? rateAcc_ff + RAMP_FULL_RPM : rateAcc_ff;
    nxt_velRef = velRef_ff;
    nxt_rateAcc = accSum;
    if (!rampActive || !servo_on_input) begin
      // ramp off: hold at rest
      nxt_velRef  = 16'sh0000;
      nxt_rateAcc = 32'h0000_0000;
    end else if (velRef_ff == rampTarget) begin
      // on target: drop stale credit
      nxt_rateAcc = 32'h0000_0000;
    end else if (accSum >= {16'h0000, activePeriod}) begin
      // one rpm step per spent period
      nxt_rateAcc = accSum - {16'h0000, activePeriod};
      nxt_velRef  = (rampTarget > velRef_ff) ? velRef_ff + 16'sh0001
                                             : velRef_ff - 16'sh0001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      velRef_ff  <= 16'sh0000;
      rateAcc_ff <= 32'h0000_0000;
    end else begin
      velRef_ff  <= nxt_velRef;
      rateAcc_ff <= nxt_rateAcc;
    end
  end

  assign velocityRef = velRef_ff;

  // ---------------------------------------------------------------
  // torque reference selection
  // ---------------------------------------------------------------
  logic signed [15:0] torqueRef_ff, nxt_torqueRef;  // target torque, percent
  logic signed [15:0] analogScaled;                 // analog in percent
  logic signed [15:0] presetPick;                   // clamped preset
  logic signed [32:0] product;                      // analog times full scale
  logic        [1:0]  torqueSel;                    // select code
  logic               torqueMode;                   // t or tz active

  // linear scaling, full code is 10 V
  always_comb begin
    product      = 33'(analogTorque) * $signed({17'h0_0000, torque_full_scale_ff});
    analogScaled = 16'(product >>> ANALOG_FS_SHIFT);
  end

  // bit-coded preset pick with range clamp
  always_comb begin
    torqueSel = {torque_select_bit1, torque_select_bit0};
    unique case (torqueSel)
      SEL_ONE: presetPick = torquePresets.presetOne;
      SEL_TWO: presetPick = torquePresets.presetTwo;
      default: presetPick = torquePresets.presetThree;
    endcase
    if (presetPick > $signed(PRESET_LIMIT))       presetPick = $signed(PRESET_LIMIT);
    else if (presetPick < -$signed(PRESET_LIMIT)) presetPick = -$signed(PRESET_LIMIT);
  end

  always_comb begin
    torqueMode    = (opMode == torque_mode) || (opMode == torque_zero_mode);
    nxt_torqueRef = 16'sh0000;
    if (!torqueMode || !servo_on_input) begin
      nxt_torqueRef = 16'sh0000;
    end else if (torqueSel != SEL_ANALOG) begin
      nxt_torqueRef = presetPick;
    end else if (opMode == torque_mode) begin
      nxt_torqueRef = analogScaled;
    end else begin
      nxt_torqueRef = 16'sh0000;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) torqueRef_ff <= 16'sh0000;
    else       torqueRef_ff <= nxt_torqueRef;
  end

  assign torqueRef = torqueRef_ff;

  // full scale as the torque limit outside t and tz, TORQUE_FS_MAX (1000 percent) in them
  assign torqueLimit = torqueMode ? TORQUE_FS_MAX : torque_full_scale_ff;
  // power stage follows servo on, no stop ramp
  assign powerStageEnable = servo_on_input;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_accelRange;
    @(posedge clock) disable iff (reset)
      (parReq.write && parReq.addr == ADDR_ACCEL_PERIOD && !periodOk)
      |=> (accel_period_ff == $past(accel_period_ff));
  endproperty
  a_accelRange: assert property (p_accelRange)
    else $error("out of range accel period took effect");

  property p_decelWrite;
    @(posedge clock) disable iff (reset)
      (parReq.write && parReq.addr == ADDR_DECEL_PERIOD && periodOk)
      |=> (decel_period_ff == $past(parReq.wdata));
  endproperty
  a_decelWrite: assert property (p_decelWrite)
    else $error("valid decel period not stored");

  property p_fsLocked;
    @(posedge clock) disable iff (reset)
      (parReq.write && parReq.addr == ADDR_TORQUE_FS && servo_on_input)
      |=> $stable(torque_full_scale_ff);
  endproperty
  a_fsLocked: assert property (p_fsLocked)
    else $error("full scale changed while enabled");

  property p_rampStep;
    @(posedge clock) disable iff (reset)
      (rampActive && servo_on_input) ##1 (rampActive && servo_on_input)
      |-> (velRef_ff - $past(velRef_ff) <= 16'sh0001) &&
          ($past(velRef_ff) - velRef_ff <= 16'sh0001);
  endproperty
  a_rampStep: assert property (p_rampStep)
    else $error("velocity reference stepped");

  property p_rampIdle;
    @(posedge clock) disable iff (reset)
      (!rampActive) [*2] |-> (velRef_ff == 16'sh0000);
  endproperty
  a_rampIdle: assert property (p_rampIdle)
    else $error("ramp moves outside velocity and pulse modes");

  property p_coast;
    @(posedge clock) disable iff (reset)
      !servo_on_input |-> !powerStageEnable ##1 (torqueRef_ff == 16'sh0000);
  endproperty
  a_coast: assert property (p_coast)
    else $error("torque held after power disable");

  property p_presetWins;
    @(posedge clock) disable iff (reset)
      (torqueMode && servo_on_input && torqueSel != SEL_ANALOG)
      |=> (torqueRef_ff == $past(presetPick));
  endproperty
  a_presetWins: assert property (p_presetWins)
    else $error("preset did not override analog");

  property p_zeroMode;
    @(posedge clock) disable iff (reset)
      (opMode == torque_zero_mode && torqueSel == SEL_ANALOG)
      |=> (torqueRef_ff == 16'sh0000);
  endproperty
  a_zeroMode: assert property (p_zeroMode)
    else $error("torque zero mode not zero");

  property p_analog;
    @(posedge clock) disable iff (reset)
      (opMode == torque_mode && servo_on_input && torqueSel == SEL_ANALOG)
      |=> (torqueRef_ff == $past(analogScaled));
  endproperty
  a_analog: assert property (p_analog)
    else $error("analog torque not followed");

  property p_limit;
    @(posedge clock) disable iff (reset)
      !torqueMode |-> (torqueLimit == torque_full_scale_ff);
  endproperty
  a_limit: assert property (p_limit)
    else $error("torque limit differs from full scale");

endmodule

/* File: tb/servo_io_partner.sv */
`timescale 1ns/1ps
// -------------------------------------------------------------
// digital input controller and power stage request
// -------------------------------------------------------------
module servo_io_partner (
  // requests from the bench
  input  wire logic [1:0] selCode,
  input  wire logic       servoReq,
  // drive pins
  output logic            torque_select_bit0,
  output logic            torque_select_bit1,
  output logic            servo_on_input
);
  assign torque_select_bit0 = selCode[0];
  assign torque_select_bit1 = selCode[1];
  // disable request, motor left to coast
  assign servo_on_input     = servoReq;
endmodule

/* File: tb/test_servo_ramp_torque_reference.sv */
`timescale 1ns/1ps
module test_servo_ramp_torque_reference;
  import servo_ref_pkg::*;
  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  logic                 clock = 1'b0;
  logic                 reset = 1'b1;
  parReq_s              parReq = '0;
  logic [15:0]          parRdData;
  opMode_e              opMode = torque_mode;
  logic [1:0]           selCode = 2'h0;
  logic                 servoReq = 1'b0;
  logic                 servo_on_input, torque_select_bit0, torque_select_bit1;
  logic signed [15:0]   velocityTarget = '0, pulse_train_input = '0, analogTorque = '0;
  torquePreset_s        torquePresets = '{16'sh004b, -16'sh0078, 16'sh0190};
  logic signed [15:0]   velocityRef, torqueRef;
  logic [15:0]          torqueLimit;
  logic                 powerStageEnable;
  int                   bad_count = 0;
  int                   checks_done = 0;
  // table row: inputs then expected torque and limit
  typedef struct packed {
    opMode_e m; logic [1:0] s; logic on; logic [15:0] a, t, l;
  } row_s;
  row_s rows [10];

  always #10 clock = ~clock;

  servo_io_partner partner (.selCode(selCode), .servoReq(servoReq),
    .torque_select_bit0(torque_select_bit0), .torque_select_bit1(torque_select_bit1),
    .servo_on_input(servo_on_input));

  servo_ramp_torque_reference #(.TICK_CYCLES(50)) dut (.clock(clock), .reset(reset),
    .parReq(parReq), .parRdData(parRdData), .opMode(opMode),
    .servo_on_input(servo_on_input), .torque_select_bit0(torque_select_bit0),
    .torque_select_bit1(torque_select_bit1), .velocityTarget(velocityTarget),
    .pulse_train_input(pulse_train_input), .analogTorque(analogTorque),
    .torquePresets(torquePresets), .velocityRef(velocityRef), .torqueRef(torqueRef),
    .torqueLimit(torqueLimit), .powerStageEnable(powerStageEnable));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d of %0d checks", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clock);
    parReq <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    parReq.write <= 1'b0;
  endtask

  // read strobe, answer sampled the cycle after
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clock);
    parReq <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clock);
    parReq.read <= 1'b0;
    #1 check(parRdData, exp);
  endtask

  // bounded wait on the ramp output
  task automatic waitVel(input logic [15:0] v);
    int n;
    n = 0;
    while (velocityRef !== v && n < 400) begin
      @(posedge clock);
      #1 n++;
    end
    // a timeout is only a timeout if the target is still not reached
    if (velocityRef !== v) begin
      bad_count++;
      stop_test();
    end
    check(velocityRef, v);
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    rows = '{'{torque_mode, 2'h0, 1'b1, 16'h4000, 16'h0032, 16'h03e8},
             '{torque_mode, 2'h1, 1'b1, 16'h4000, 16'h004b, 16'h03e8},
             '{torque_mode, 2'h2, 1'b1, 16'h4000, 16'hff88, 16'h03e8},
             '{torque_mode, 2'h3, 1'b1, 16'h4000, 16'h012c, 16'h03e8},
             '{torque_zero_mode, 2'h0, 1'b1, 16'h4000, 16'h0000, 16'h03e8},
             '{torque_zero_mode, 2'h3, 1'b1, 16'h4000, 16'h012c, 16'h03e8},
             '{torque_mode, 2'h1, 1'b0, 16'h4000, 16'h0000, 16'h03e8},
             '{velocity_mode, 2'h1, 1'b1, 16'h4000, 16'h0000, 16'h0064},
             '{pulse_train_mode, 2'h0, 1'b1, 16'h4000, 16'h0000, 16'h0064},
             '{internal_position_mode, 2'h2, 1'b1, 16'h4000, 16'h0000, 16'h0064}};
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    // reset values and unmapped read
    rd(ADDR_ACCEL_PERIOD, 16'h001e);
    rd(ADDR_DECEL_PERIOD, 16'h001e);
    rd(ADDR_TORQUE_FS, 16'h0064);
    rd(12'h0248, 16'h0000);
    // torque selection table
    foreach (rows[i]) begin
      @(posedge clock);
      opMode <= rows[i].m;
      selCode <= rows[i].s;
      servoReq <= rows[i].on;
      analogTorque <= rows[i].a;
      @(posedge clock);
      @(posedge clock);
      #1 check(torqueRef, rows[i].t);
      check(torqueLimit, rows[i].l);
      check({15'h0000, powerStageEnable}, {15'h0000, rows[i].on});
    end
    // full scale locked while powered
    wr(ADDR_TORQUE_FS, 16'h00c8);
    rd(ADDR_TORQUE_FS, 16'h0064);
    @(posedge clock);
    servoReq <= 1'b0;
    wr(ADDR_TORQUE_FS, 16'h03e9);
    rd(ADDR_TORQUE_FS, 16'h0064);
    wr(ADDR_TORQUE_FS, 16'h03e8);
    rd(ADDR_TORQUE_FS, 16'h03e8);
    @(posedge clock);
    opMode <= torque_mode;
    selCode <= 2'h0;
    servoReq <= 1'b1;
    repeat (2) @(posedge clock);
    #1 check(torqueRef, 16'h01f4);
    // period range boundaries
    wr(ADDR_ACCEL_PERIOD, 16'h0005);
    rd(ADDR_ACCEL_PERIOD, 16'h001e);
    wr(ADDR_DECEL_PERIOD, 16'hffdd);
    rd(ADDR_DECEL_PERIOD, 16'h001e);
    wr(ADDR_DECEL_PERIOD, 16'hffdc);
    rd(ADDR_DECEL_PERIOD, 16'hffdc);
    wr(ADDR_ACCEL_PERIOD, 16'h0006);
    rd(ADDR_ACCEL_PERIOD, 16'h0006);
    // fast velocity ramp, then coast on disable
    @(posedge clock);
    opMode <= velocity_mode;
    velocityTarget <= 16'sh0064;
    waitVel(16'h0064);
    @(posedge clock);
    servoReq <= 1'b0;
    @(posedge clock);
    @(posedge clock);
    #1 check(velocityRef, 16'h0000);
    // slow pulse-train ramp: one rpm per tick, four ticks in 200 cycles
    wr(ADDR_ACCEL_PERIOD, 16'h1770);
    @(posedge clock);
    opMode <= pulse_train_mode;
    pulse_train_input <= 16'sh03e8;
    servoReq <= 1'b1;
    repeat (200) @(posedge clock);
    #1 check(velocityRef, 16'h0004);
    // fast deceleration back to standstill
    wr(ADDR_DECEL_PERIOD, 16'h0006);
    @(posedge clock);
    pulse_train_input <= 16'sh0000;
    waitVel(16'h0000);
    // mid-run reset: outputs cleared, parameters back to defaults
    @(posedge clock);
    reset <= 1'b1;
    opMode <= torque_mode;
    selCode <= 2'h0;
    repeat (2) @(posedge clock);
    #1 check(torqueRef, 16'h0000);
    check(parRdData, 16'h0000);
    @(posedge clock);
    reset <= 1'b0;
    rd(ADDR_ACCEL_PERIOD, 16'h001e);
    rd(ADDR_DECEL_PERIOD, 16'h001e);
    rd(ADDR_TORQUE_FS, 16'h0064);
    // default full scale scales half-range analog to 50 percent
    check(torqueRef, 16'h0032);
    stop_test();
  end
endmodule
